// >>> hsmid_decode.sv
// hsmid_decode.sv: decode and execute of halfword stores, user-level
// stores and subtract immediate.
// assumes: register file reads are combinational and arrive in the same
// cycle as the instruction; results are registered one cycle later.
//
// Function
// RULE1: immediate halfword store offset, index, low halfword
// RULE2: writeback stores offset address into base
// RULE3: register store shift 0..3; short form unshifted
// RULE4: wide register store shift from shift field
// RULE5: wide register store SP/PC source/offset unpredictable
// RULE6: register store address base plus shifted offset
// RULE7: wide stores with base 1111 are undefined
// RULE8: user-level stores use unprivileged access
// RULE9: user halfword store base plus byte immediate
// RULE10: user word store writes full word
// RULE11: user stores SP/PC source unpredictable
// RULE12: short subtract sets flags outside conditional block
// RULE13: short byte subtract shares operand/destination field
// RULE14: wide subtract flags by S, expanded immediate
// RULE15: destination 1111 with S compares; base 1101 SP
// RULE16: wide subtract SP/PC destination or PC base unpredictable
// RULE17: subtract as add inverted plus one; NZCV
// RULE18: undefined raises exception, no side effects
`timescale 1ns/1ps
module hsmid_decode
   import hsmid_pkg::*;
(
   input wire logic mclk, // core clock, 100 MHz
   input wire logic rst, // asynchronous, active high
   input wire logic instr_valid, // instruction present this cycle
   input wire logic instr_wide, // instruction is 32-bit
   input wire logic [31:0] instr, // 32-bit: first halfword in [31:16]
   input wire logic in_cond_block, // inside conditional execution block
   output logic [3:0] rd_a_sel, // read port a: base / first operand
   output logic [3:0] rd_b_sel, // read port b: offset register
   output logic [3:0] rd_c_sel, // read port c: source register
   input wire logic [31:0] rd_a, // value of rd_a_sel
   input wire logic [31:0] rd_b, // value of rd_b_sel
   input wire logic [31:0] rd_c, // value of rd_c_sel
   output logic wr_en, // register writeback strobe
   output logic [3:0] wr_sel, // register to write
   output logic [31:0] wr_data, // value written
   output logic flags_en, // flags update strobe
   output logic [3:0] flags_nzcv, // new N,Z,C,V
   output logic mem_wr, // memory write strobe
   output logic [31:0] mem_addr, // memory address
   output logic [31:0] mem_data, // write data, halfword in low bits
   output logic [1:0] mem_size, // 1: halfword, 2: word
   output logic mem_user, // access made as unprivileged
   output logic undef_exc, // undefined instruction pulse
   output logic unpred, // unpredictable encoding pulse
   output hsmid_op_type op_class // class of last executed instruction
);
   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // modified immediate expansion for the wide subtract
   function automatic logic [31:0] expand_imm(input logic [11:0] v);
      logic [7:0] b;
      logic [31:0] r;
      b = v[7:0];
      r = 32'h0;
      if (v[11:10] == 2'b00) begin
         unique case (v[9:8])
            2'b00: r = {24'h0, b};
            2'b01: r = {8'h0, b, 8'h0, b};
            2'b10: r = {b, 8'h0, b, 8'h0};
            2'b11: r = {b, b, b, b};
         endcase
      end else begin
         r = {24'h0, 1'b1, v[6:0]};
         r = (r >> v[11:7]) | (r << (6'd32 - {1'b0, v[11:7]}));
      end
      return r;
   endfunction
   // register 13 or 15
   function automatic logic sp_or_pc(input logic [3:0] r);
      return (r == `HSMID_REG_SP) || (r == `HSMID_REG_PC);
   endfunction

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   logic [15:0] hi; // first halfword
   logic [15:0] lo; // second halfword or short instruction
   logic [3:0] base_reg_field;
   logic [3:0] source_reg_field;
   logic [3:0] offset_reg_field;
   logic [7:0] byte_immediate_field;
   logic [2:0] three_bit_immediate_field;
   logic [1:0] shift_amount_field;
   hsmid_op_type next_op;
   logic [31:0] imm; // zero-extended or expanded operand
   logic use_reg_off; // offset comes from rd_b
   logic [1:0] shamt;
   logic add_off, index, wback, setflags, user, is_undef, is_unpred;
   logic [3:0] dest;
   logic [1:0] size;

   assign hi = instr[31:16];
   assign lo = instr[15:0];
   assign byte_immediate_field = lo[7:0];
   assign three_bit_immediate_field = lo[14:12];
   assign shift_amount_field = lo[5:4];

   // combinational field extraction and classification
   always_comb begin
      next_op = HSMID_NONE;
      base_reg_field = 4'h0;
      source_reg_field = 4'h0;
      offset_reg_field = 4'h0;
      imm = 32'h0;
      use_reg_off = 1'b0;
      shamt = 2'b00;
      add_off = 1'b1;
      index = 1'b1;
      wback = 1'b0;
      setflags = 1'b0;
      user = 1'b0;
      is_undef = 1'b0;
      is_unpred = 1'b0;
      dest = 4'h0;
      size = 2'd1;
      if (!instr_wide) begin
         if (lo[15:11] == `HSMID_OP16_HST_IMM) begin
            // short immediate store, halfword-scaled offset
            next_op = HSMID_STORE_H;
            base_reg_field = {1'b0, lo[5:3]};
            source_reg_field = {1'b0, lo[2:0]};
            imm = {26'h0, lo[10:6], 1'b0};
         end else if (lo[15:9] == `HSMID_OP16_HST_REG) begin
            // short register store: no shift, indexed, no writeback
            next_op = HSMID_STORE_H; // RULE3
            base_reg_field = {1'b0, lo[5:3]};
            source_reg_field = {1'b0, lo[2:0]};
            offset_reg_field = {1'b0, lo[8:6]};
            use_reg_off = 1'b1;
         end else if (lo[15:9] == `HSMID_OP16_SUB3) begin
            next_op = HSMID_SUB;
            base_reg_field = {1'b0, lo[5:3]};
            dest = {1'b0, lo[2:0]};
            imm = {29'h0, lo[8:6]};
            setflags = !in_cond_block; // RULE12
         end else if (lo[15:11] == `HSMID_OP16_SUB8) begin
            next_op = HSMID_SUB;
            base_reg_field = {1'b0, lo[10:8]}; // RULE13
            dest = {1'b0, lo[10:8]}; // RULE13
            imm = {24'h0, lo[7:0]};
            setflags = !in_cond_block; // RULE12
         end
      end else begin
         base_reg_field = hi[3:0];
         source_reg_field = lo[15:12];
         offset_reg_field = lo[3:0];
         if (hi[15:4] == `HSMID_OP32_HST_T2) begin
            next_op = HSMID_STORE_H;
            imm = {20'h0, lo[11:0]};
            is_unpred = sp_or_pc(source_reg_field);
            is_undef = (base_reg_field == `HSMID_REG_PC); // RULE7
         end else if (hi[15:4] == `HSMID_OP32_HST_T3 && !lo[11]
            && lo[11:6] == 6'h00) begin
            // wide register store with shift field
            next_op = HSMID_STORE_H;
            use_reg_off = 1'b1;
            shamt = shift_amount_field; // RULE4
            is_unpred = sp_or_pc(source_reg_field)
               || sp_or_pc(offset_reg_field); // RULE5
            is_undef = (base_reg_field == `HSMID_REG_PC); // RULE7
         end else if ((hi[15:4] == `HSMID_OP32_HST_T3
            || hi[15:4] == `HSMID_OP32_WST_T) && lo[11]) begin
            next_op = (hi[6:5] == 2'b10) ? HSMID_STORE_W : HSMID_STORE_H;
            size = (hi[6:5] == 2'b10) ? 2'd2 : 2'd1;
            imm = {24'h0, byte_immediate_field};
            is_unpred = sp_or_pc(source_reg_field); // RULE11
            is_undef = (base_reg_field == `HSMID_REG_PC); // RULE7
            if (lo[11:8] == `HSMID_LO_USER) begin
               user = 1'b1; // RULE8
            end else if (hi[15:4] == `HSMID_OP32_HST_T3) begin
               // pre/post indexed halfword store with P,U,W
               index = lo[10];
               add_off = lo[9];
               wback = lo[8];
               is_unpred = is_unpred
                  || (lo[8] && base_reg_field == source_reg_field);
               is_undef = is_undef || (!lo[10] && !lo[8]); // RULE7
            end else begin
               next_op = HSMID_NONE; // other word store forms elsewhere
               is_undef = 1'b0;
               is_unpred = 1'b0;
               user = 1'b0;
            end
         end else if (hi[15:11] == `HSMID_OP32_SUB_HI && !hi[9]
            && hi[8:5] == 4'hD && !lo[15]) begin
            dest = lo[11:8];
            setflags = hi[4]; // RULE14
            imm = expand_imm({hi[10], three_bit_immediate_field,
               byte_immediate_field}); // RULE14
            if (dest == `HSMID_REG_PC && hi[4]) begin
               next_op = HSMID_CMP; // RULE15
            end else if (base_reg_field == `HSMID_REG_SP) begin
               next_op = HSMID_SP_SUB; // RULE15
            end else begin
               next_op = HSMID_SUB;
               is_unpred = (dest == `HSMID_REG_SP)
                  || (dest == `HSMID_REG_PC && !hi[4])
                  || (base_reg_field == `HSMID_REG_PC); // RULE16
            end
         end
      end
   end

   assign rd_a_sel = base_reg_field;
   assign rd_b_sel = offset_reg_field;
   assign rd_c_sel = source_reg_field;

   // ----------------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------------
   logic [31:0] offset; // immediate or shifted offset register
   logic [31:0] offset_addr; // base +/- offset
   logic [32:0] diff; // first operand + ~imm + 1
   logic go; // legal, recognised instruction
   logic is_store;
   assign offset = use_reg_off ? (rd_b << shamt) : imm; // RULE3 RULE6
   assign offset_addr = add_off ? rd_a + offset : rd_a - offset; // RULE1
   assign diff = {1'b0, rd_a} + {1'b0, ~imm} + 33'h1; // RULE17
   assign go = instr_valid && !is_undef && next_op != HSMID_NONE;
   assign is_store = next_op == HSMID_STORE_H || next_op == HSMID_STORE_W;

   // memory write port; undefined encodings never reach memory
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mem_wr <= 1'b0;
         mem_addr <= 32'h0;
         mem_data <= 32'h0;
         mem_size <= 2'd0;
         mem_user <= 1'b0;
      end else begin
         mem_wr <= go && is_store; // RULE18
         if (go && is_store) begin
            mem_addr <= index ? offset_addr : rd_a; // RULE1 RULE6 RULE9
            mem_data <= (size == 2'd2) ? rd_c
               : {16'h0, rd_c[15:0]}; // RULE1 RULE10
            mem_size <= size;
            mem_user <= user; // RULE8
         end
      end
   end

   // register writeback: base update or subtract result
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_en <= 1'b0;
         wr_sel <= 4'h0;
         wr_data <= 32'h0;
      end else begin
         wr_en <= go && ((is_store && wback) || next_op == HSMID_SUB);
         if (go && is_store && wback) begin
            wr_sel <= base_reg_field; // RULE2
            wr_data <= offset_addr; // RULE2
         end else if (go && next_op == HSMID_SUB) begin
            wr_sel <= dest;
            wr_data <= diff[31:0]; // RULE17
         end
      end
   end

   // condition flags; compare updates flags without a result write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flags_en <= 1'b0;
         flags_nzcv <= 4'h0;
      end else begin
         flags_en <= go && setflags
            && (next_op == HSMID_SUB || next_op == HSMID_CMP);
         // stack subtract is handled elsewhere; keep the held flags intact
         if (go && setflags && next_op != HSMID_SP_SUB) begin
            flags_nzcv <= {diff[31], diff[31:0] == 32'h0, diff[32],
               (rd_a[31] != imm[31]) && (diff[31] != rd_a[31])}; // RULE17
         end
      end
   end

   // exception and status pulses
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         undef_exc <= 1'b0;
         unpred <= 1'b0;
         op_class <= HSMID_NONE;
      end else begin
         undef_exc <= instr_valid && is_undef; // RULE18
         unpred <= go && is_unpred; // RULE5 RULE11 RULE16
         if (instr_valid) begin
            op_class <= is_undef ? HSMID_NONE : next_op;
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   a_undef_quiet: assert property (@(posedge mclk) disable iff (rst) // RULE18
      undef_exc |-> !mem_wr && !wr_en && !flags_en)
      else $error("undefined instruction had side effects");
   a_undef_base: assert property (@(posedge mclk) disable iff (rst) // RULE7
      instr_valid && instr_wide && is_store && rd_a_sel == 4'hF
      |=> undef_exc && !mem_wr)
      else $error("base 1111 store not undefined");
   a_user_access: assert property (@(posedge mclk) disable iff (rst) // RULE8
      go && user |=> mem_wr && mem_user)
      else $error("user-level store not unprivileged");
   a_half_data: assert property (@(posedge mclk) disable iff (rst) // RULE1
      go && next_op == HSMID_STORE_H |=> mem_data[31:16] == 16'h0
      && mem_size == 2'd1)
      else $error("halfword store data not low halfword");
   a_word_data: assert property (@(posedge mclk) disable iff (rst) // RULE10
      go && next_op == HSMID_STORE_W |=> mem_data == $past(rd_c))
      else $error("word store data mismatch");
   a_wback_base: assert property (@(posedge mclk) disable iff (rst) // RULE2
      go && is_store && wback |=> wr_en && wr_sel == $past(rd_a_sel))
      else $error("writeback missing");
   a_flags_cond: assert property (@(posedge mclk) disable iff (rst) // RULE12
      go && !instr_wide && next_op == HSMID_SUB && in_cond_block
      |=> !flags_en)
      else $error("flags updated inside conditional block");
   a_cmp_nowrite: assert property (@(posedge mclk) disable iff (rst) // RULE15
      go && next_op == HSMID_CMP |=> flags_en && !wr_en)
      else $error("compare wrote a register");
   a_sub_result: assert property (@(posedge mclk) disable iff (rst) // RULE17
      go && next_op == HSMID_SUB |=> wr_data == $past(rd_a) - $past(imm))
      else $error("subtract result wrong");
   a_reg_addr: assert property (@(posedge mclk) disable iff (rst) // RULE6
      go && use_reg_off |=> mem_addr == $past(rd_a) + ($past(rd_b)
      << $past(shamt)))
      else $error("register store address wrong");
endmodule

// >>> hsmid_map.svh
// hsmid_map.svh: opcode patterns, field positions and constants for the
// halfword store / minus immediate decoder.
// assumes: included by the package file, whose definitions the decoder then uses; definitions only.
`ifndef HSMID_MAP_SVH
`define HSMID_MAP_SVH
// ----------------------------------------------------------------------
// register numbers
// ----------------------------------------------------------------------
`define HSMID_REG_SP 4'hD
`define HSMID_REG_PC 4'hF
// ----------------------------------------------------------------------
// 16-bit opcode prefixes
// ----------------------------------------------------------------------
`define HSMID_OP16_HST_IMM 5'h10
`define HSMID_OP16_HST_REG 7'h29
`define HSMID_OP16_SUB3 7'h0F
`define HSMID_OP16_SUB8 5'h07
// ----------------------------------------------------------------------
// 32-bit opcode prefixes (upper halfword, base field excluded) and the user-store lower-halfword field
// ----------------------------------------------------------------------
`define HSMID_OP32_HST_T2 12'hF8A
`define HSMID_OP32_HST_T3 12'hF82
`define HSMID_OP32_WST_T 12'hF84
`define HSMID_OP32_SUB_HI 5'h1E
`define HSMID_OP32_SUB_MID 5'h0D
`define HSMID_LO_USER 4'hE
`endif

// >>> hsmid_pkg.sv
// hsmid_pkg.sv: types shared by the decoder.
// assumes: nothing beyond the map header.
`include "hsmid_map.svh"
package hsmid_pkg;
   // class of the instruction in the execute slot
   typedef enum logic [2:0] {
      HSMID_NONE,
      HSMID_STORE_H,
      HSMID_STORE_W,
      HSMID_SUB,
      HSMID_CMP,
      HSMID_SP_SUB
   } hsmid_op_type;
endpackage

// >>> hsmid_regfile_model.sv
// hsmid_regfile_model.sv: behavioural register file on the far side of
// the decoder, with three combinational read ports and one write port.
// assumes: the bench preloads registers through the load port while no
// instruction is in flight; register i resets to the value i.
`timescale 1ns/1ps
module hsmid_regfile_model (
   input wire logic mclk, // core clock
   input wire logic rst, // asynchronous, active high
   input wire logic [3:0] rd_a_sel, // base / first operand select
   input wire logic [3:0] rd_b_sel, // offset select
   input wire logic [3:0] rd_c_sel, // source select
   output logic [31:0] rd_a, // value of rd_a_sel
   output logic [31:0] rd_b, // value of rd_b_sel
   output logic [31:0] rd_c, // value of rd_c_sel
   input wire logic wr_en, // writeback strobe from the decoder
   input wire logic [3:0] wr_sel, // register written back
   input wire logic [31:0] wr_data, // writeback value
   input wire logic load_en, // bench preload strobe
   input wire logic [3:0] load_sel, // register preloaded
   input wire logic [31:0] load_val // preload value
);
   logic [31:0] regs [16]; // register contents
   // ---------------------------------------------------------------
   // read ports
   // ---------------------------------------------------------------
   // reads are combinational, matching the decoder's same-cycle use
   assign rd_a = regs[rd_a_sel];
   assign rd_b = regs[rd_b_sel];
   assign rd_c = regs[rd_c_sel];
   // ---------------------------------------------------------------
   // write port
   // ---------------------------------------------------------------
   // preload wins over writeback; the bench never overlaps them
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            regs[i] <= 32'(i);
         end
      end else if (load_en) begin
         regs[load_sel] <= load_val;
      end else if (wr_en) begin
         regs[wr_sel] <= wr_data;
      end
   end
endmodule

// >>> tb.sv
// tb.sv: self-checking bench for the halfword store / subtract decoder.
// assumes: hsmid_pkg and the register file model are compiled first.
`timescale 1ns/1ps
module tb;
   import hsmid_pkg::*;
   logic mclk, rst, instr_valid, instr_wide, in_cond_block;
   logic [31:0] instr, rd_a, rd_b, rd_c, wr_data, mem_addr, mem_data;
   logic [3:0] rd_a_sel, rd_b_sel, rd_c_sel, wr_sel, flags_nzcv;
   logic wr_en, flags_en, mem_wr, mem_user, undef_exc, unpred;
   logic [1:0] mem_size;
   hsmid_op_type op_class;
   logic load_en;
   logic [3:0] load_sel;
   logic [31:0] load_val;
   int err_total = 0; // mismatches seen
   int check_count = 0; // comparisons made
   localparam logic [31:0] BASE = 32'h2000_0100; // base register value
   hsmid_decode hsmid_decode_inst (.mclk(mclk), .rst(rst),
      .instr_valid(instr_valid), .instr_wide(instr_wide), .instr(instr),
      .in_cond_block(in_cond_block), .rd_a_sel(rd_a_sel),
      .rd_b_sel(rd_b_sel), .rd_c_sel(rd_c_sel), .rd_a(rd_a), .rd_b(rd_b),
      .rd_c(rd_c), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
      .flags_en(flags_en), .flags_nzcv(flags_nzcv), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_data(mem_data), .mem_size(mem_size),
      .mem_user(mem_user), .undef_exc(undef_exc), .unpred(unpred),
      .op_class(op_class));
   hsmid_regfile_model hsmid_regfile_model_inst (.mclk(mclk), .rst(rst),
      .rd_a_sel(rd_a_sel), .rd_b_sel(rd_b_sel), .rd_c_sel(rd_c_sel),
      .rd_a(rd_a), .rd_b(rd_b), .rd_c(rd_c), .wr_en(wr_en),
      .wr_sel(wr_sel), .wr_data(wr_data), .load_en(load_en),
      .load_sel(load_sel), .load_val(load_val));
   // ---------------------------------------------------------------
   // clock, helpers
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // compare one value and count it
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // preload one register; waits a falling edge first so no signal is
   // assigned twice in one time step
   task automatic put(input logic [3:0] s, input logic [31:0] v);
      @(negedge mclk);
      load_en = 1'b1;
      load_sel = s;
      load_val = v;
   endtask
   // issue one instruction; on return its registered results are settled
   task automatic exec(input logic w, input logic [31:0] ins);
      @(negedge mclk);
      load_en = 1'b0;
      instr_valid = 1'b1;
      instr_wide = w;
      instr = ins;
      @(negedge mclk);
      instr_valid = 1'b0;
   endtask
   // base, offset 6 and source value in r1..r3
   task automatic setup();
      put(4'h1, BASE);
      put(4'h2, 32'h0000_0006);
      put(4'h3, 32'hCAFE_BEEF);
   endtask
   // check a store's memory strobe, address, data, size and level
   task automatic st(input logic [31:0] a, input logic [31:0] d,
                     input logic [1:0] sz, input logic u);
      chk("mem_wr", 32'h1, 32'(mem_wr));
      chk("mem_addr", a, mem_addr);
      chk("mem_data", d, mem_data);
      chk("mem_size", 32'(sz), 32'(mem_size));
      chk("mem_user", 32'(u), 32'(mem_user));
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // short immediate store at the largest offset, then wide pre-indexed
   // subtract with writeback and post-indexed add with writeback
   task automatic t_imm_store();
      setup();
      exec(1'b0, 32'h0000_87CB);
      st(BASE + 32'h3E, 32'h0000_BEEF, 2'h1, 1'b0);
      chk("wr_en", 32'h0, 32'(wr_en));
      exec(1'b1, 32'hF821_3D10);
      st(BASE - 32'h10, 32'h0000_BEEF, 2'h1, 1'b0);
      chk("wr_en", 32'h1, 32'(wr_en));
      chk("wr_sel", 32'h1, 32'(wr_sel));
      chk("wr_data", BASE - 32'h10, wr_data);
      exec(1'b1, 32'hF821_3B20);
      st(BASE - 32'h10, 32'h0000_BEEF, 2'h1, 1'b0);
      chk("wr_data", BASE + 32'h10, wr_data);
   endtask
   // register offset: short form unshifted, wide form every shift
   task automatic t_reg_store();
      setup();
      exec(1'b0, 32'h0000_528B);
      st(BASE + 32'h6, 32'h0000_BEEF, 2'h1, 1'b0);
      chk("wr_en", 32'h0, 32'(wr_en));
      for (int sh = 0; sh < 4; sh++) begin
         exec(1'b1, 32'hF821_3002 | 32'(sh << 4));
         st(BASE + (32'h6 << sh), 32'h0000_BEEF, 2'h1, 1'b0);
      end
   endtask
   // base field 1111 on a wide store: exception, no side effects
   task automatic t_undef();
      setup();
      exec(1'b1, 32'hF82F_3002);
      chk("undef_exc", 32'h1, 32'(undef_exc));
      chk("mem_wr", 32'h0, 32'(mem_wr));
      chk("wr_en", 32'h0, 32'(wr_en));
      chk("op_class", 32'(HSMID_NONE), 32'(op_class));
   endtask
   // user-level halfword and word stores at immediate 255
   task automatic t_user();
      setup();
      exec(1'b1, 32'hF821_3EFF);
      st(BASE + 32'hFF, 32'h0000_BEEF, 2'h1, 1'b1);
      chk("wr_en", 32'h0, 32'(wr_en));
      exec(1'b1, 32'hF841_3EFF);
      st(BASE + 32'hFF, 32'hCAFE_BEEF, 2'h2, 1'b1);
      chk("op_class", 32'(HSMID_STORE_W), 32'(op_class));
   endtask
   // source or offset of 13/15 flags the encoding yet still stores
   task automatic t_unpred_store();
      logic [31:0] ins [4];
      ins = '{32'hF821_D002, 32'hF821_300F, 32'hF821_FEFF, 32'hF841_DEFF};
      setup();
      for (int k = 0; k < 4; k++) begin
         exec(1'b1, ins[k]);
         chk("unpred", 32'h1, 32'(unpred));
         chk("mem_wr", 32'h1, 32'(mem_wr));
      end
   endtask
   // short subtracts: flag update hinges on the conditional block
   task automatic t_sub_short();
      put(4'h4, 32'h0000_0005);
      in_cond_block = 1'b0;
      exec(1'b0, 32'h0000_1FE5);
      chk("wr_data", 32'hFFFF_FFFE, wr_data);
      chk("wr_sel", 32'h5, 32'(wr_sel));
      chk("flags_en", 32'h1, 32'(flags_en));
      chk("nzcv", 32'h8, 32'(flags_nzcv));
      in_cond_block = 1'b1;
      exec(1'b0, 32'h0000_1FE5);
      chk("flags_en", 32'h0, 32'(flags_en));
      chk("wr_en", 32'h1, 32'(wr_en));
      in_cond_block = 1'b0;
      exec(1'b0, 32'h0000_3C05);
      chk("wr_sel", 32'h4, 32'(wr_sel));
      chk("wr_data", 32'h0, wr_data);
      chk("nzcv", 32'h6, 32'(flags_nzcv));
   endtask
   // wide subtract: S bit, expanded immediate, compare, stack, bad dest
   task automatic t_sub_wide();
      put(4'h4, 32'h8000_0000);
      exec(1'b1, 32'hF1B4_0601);
      chk("wr_data", 32'h7FFF_FFFF, wr_data);
      chk("flags_en", 32'h1, 32'(flags_en));
      chk("nzcv", 32'h3, 32'(flags_nzcv));
      exec(1'b1, 32'hF1A4_1601);
      chk("wr_data", 32'h7FFE_FFFF, wr_data);
      chk("flags_en", 32'h0, 32'(flags_en));
      exec(1'b1, 32'hF1B4_0F01);
      chk("op_class", 32'(HSMID_CMP), 32'(op_class));
      chk("cmp wr_en", 32'h0, 32'(wr_en));
      chk("cmp flags_en", 32'h1, 32'(flags_en));
      exec(1'b1, 32'hF1BD_0601);
      chk("op_class", 32'(HSMID_SP_SUB), 32'(op_class));
      chk("sp wr_en", 32'h0, 32'(wr_en));
      exec(1'b1, 32'hF1A4_0D01);
      chk("unpred", 32'h1, 32'(unpred));
   endtask
   // ---------------------------------------------------------------
   // verdict, watchdog, main sequence
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // the tests need well under 200 cycles; 5000 means a hang
   initial begin
      #50000;
      err_total++;
      print_verdict();
   end
   initial begin
      rst = 1'b1;
      instr_valid = 1'b0;
      instr_wide = 1'b0;
      instr = 32'h0;
      in_cond_block = 1'b0;
      load_en = 1'b0;
      load_sel = 4'h0;
      load_val = 32'h0;
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      t_imm_store();
      t_reg_store();
      t_undef();
      t_user();
      t_unpred_store();
      t_sub_short();
      t_sub_wide();
      print_verdict();
   end
endmodule
